// ===== include/tmr_defs.svh
// Register offsets, field positions, reset values and divider taps of the 8-bit timer
`ifndef TMR_DEFS_SVH
`define TMR_DEFS_SVH

`define TMR_ADDR_W 8
`define TMR_OFS_CTRL 8'h00
`define TMR_OFS_CSR 8'h04
`define TMR_OFS_CONST_A 8'h08
`define TMR_OFS_CONST_B 8'h0C
`define TMR_OFS_CNT 8'h10
`define TMR_OFS_SHARED_SERIAL_TIMER_CTRL 8'h14

`define TMR_CTRL_RST 8'h00
`define TMR_CSR_RST 8'h10
`define TMR_CONST_RST 8'hFF
`define TMR_CNT_RST 8'h00
`define TMR_SHARED_SERIAL_TIMER_CTRL_RST 8'h00
`define TMR_CNT_MAX 8'hFF

`define TMR_CTRL_IE_HI 7
`define TMR_CTRL_IE_LO 5
`define TMR_CTRL_CCLR_HI 4
`define TMR_CTRL_CCLR_LO 3
`define TMR_CTRL_CKS_HI 2
`define TMR_CTRL_CKS_LO 0
`define TMR_CSR_FLAG_HI 7
`define TMR_CSR_FLAG_LO 5
`define TMR_CSR_FLAG_B 7
`define TMR_CSR_FLAG_A 6
`define TMR_CSR_FLAG_WRAP 5
`define TMR_CSR_FIXED 4
`define TMR_CSR_OS_B_HI 3
`define TMR_CSR_OS_B_LO 2
`define TMR_CSR_OS_A_HI 1
`define TMR_CSR_OS_A_LO 0
`define TMR_SHARED_SERIAL_TIMER_CTRL_RANGE_HI 1
`define TMR_SHARED_SERIAL_TIMER_CTRL_RANGE_LO 0

`define TMR_CCLR_NONE 2'h0
`define TMR_CCLR_MATCH_A 2'h1
`define TMR_CCLR_MATCH_B 2'h2
`define TMR_CCLR_EXT 2'h3

`define TMR_ACT_KEEP 2'h0
`define TMR_ACT_LOW 2'h1
`define TMR_ACT_HIGH 2'h2
`define TMR_ACT_TOGGLE 2'h3

`define TMR_PS_W 11
`define TMR_TAP_DIV2 0
`define TMR_TAP_DIV8 2
`define TMR_TAP_DIV32 4
`define TMR_TAP_DIV64 5
`define TMR_TAP_DIV128 6
`define TMR_TAP_DIV256 7
`define TMR_TAP_DIV1024 9
`define TMR_TAP_DIV2048 10

`endif

// ===== include/tmr_pkg.sv
// Types shared by the 8-bit timer modules
package tmr_pkg;

  typedef enum logic [2:0] {
    SRC_STOP,
    SRC_INT,
    SRC_EXT_RISE,
    SRC_EXT_FALL,
    SRC_EXT_BOTH
  } tmr_src_t;

  typedef struct packed {
    logic match_b;
    logic match_a;
    logic wrap;
  } tmr_irq_t;

endpackage

// ===== logic/tmr_clk_sel.sv
// Count clock selection and count pulse generation for one timer channel
`timescale 1ns/1ns
`include "tmr_defs.svh"

module tmr_clk_sel #(
  parameter bit CHANNEL = 1'b0
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [2:0] clk_sel,
  input wire logic [1:0] int_range_sel,
  input wire logic [`TMR_PS_W-1:0] prescale,
  input wire logic ext_level,
  output logic count_pulse
);
  import tmr_pkg::*;

  function automatic tmr_src_t src_of(input logic [2:0] code);
    case (code)
      3'h1, 3'h2, 3'h3: src_of = SRC_INT;
      3'h5: src_of = SRC_EXT_RISE;
      3'h6: src_of = SRC_EXT_FALL;
      3'h7: src_of = SRC_EXT_BOTH;
      default: src_of = SRC_STOP;
    endcase
  endfunction

  logic int_prev_reg;
  logic ext_prev_reg;
  tmr_src_t src;
  logic range_bit;
  logic tap_1;
  logic tap_2;
  logic tap_3;
  logic int_level;
  logic ext_rise;
  logic ext_fall;

  assign src = src_of(clk_sel);
  // Channel 1 takes the high range bit, channel 0 the low one
  assign range_bit = CHANNEL ? int_range_sel[1] : int_range_sel[0];
  assign tap_1 = range_bit ? prescale[`TMR_TAP_DIV2] : prescale[`TMR_TAP_DIV8];
  assign tap_2 = CHANNEL ? (range_bit ? prescale[`TMR_TAP_DIV128] : prescale[`TMR_TAP_DIV64])
                         : (range_bit ? prescale[`TMR_TAP_DIV32] : prescale[`TMR_TAP_DIV64]);
  assign tap_3 = CHANNEL ? (range_bit ? prescale[`TMR_TAP_DIV2048] : prescale[`TMR_TAP_DIV1024])
                         : (range_bit ? prescale[`TMR_TAP_DIV256] : prescale[`TMR_TAP_DIV1024]);
  // Stopped or external counts as a low internal level, so switching can give one pulse
  assign int_level = (src != SRC_INT) ? 1'b0 :
                     (clk_sel[1:0] == 2'h1) ? tap_1 :
                     (clk_sel[1:0] == 2'h2) ? tap_2 : tap_3;
  assign ext_rise = ext_level & ~ext_prev_reg;
  assign ext_fall = ~ext_level & ext_prev_reg;
  assign count_pulse = (int_prev_reg & ~int_level) |
                       ((src == SRC_EXT_RISE) & ext_rise) |
                       ((src == SRC_EXT_FALL) & ext_fall) |
                       ((src == SRC_EXT_BOTH) & (ext_rise | ext_fall));

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      int_prev_reg <= 1'b0;
      ext_prev_reg <= 1'b0;
    end else begin
      int_prev_reg <= int_level;
      ext_prev_reg <= ext_level;
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  chk_int_falling_count: assert property ((src == SRC_INT) && int_prev_reg && !int_level |-> count_pulse)
    else $error("internal falling edge gave no count pulse");
  chk_ext_rise_count: assert property ((clk_sel == 3'h5) && !ext_prev_reg && ext_level |-> count_pulse)
    else $error("external rising edge gave no count pulse");
  chk_ext_rise_only: assert property ((clk_sel == 3'h5) && $past(clk_sel) == 3'h5 && ext_fall |-> !count_pulse)
    else $error("falling edge counted in rising mode");
endmodule

// ===== logic/tmr_top.sv
// 8-bit timer channel: APB registers, counter, compare flags and timer output
`timescale 1ns/1ns
`include "tmr_defs.svh"

module tmr_top #(
  parameter bit CHANNEL = 1'b0
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`TMR_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic standby_req,
  input wire logic ext_count_clock_pin,
  input wire logic counter_clear_pin,
  output logic timer_out_pin,
  output logic timer_out_en,
  output tmr_pkg::tmr_irq_t timer_irq
);
  import tmr_pkg::*;

  function automatic logic drive_out(input logic cur, input logic [1:0] act_a, input logic [1:0] act_b,
                                     input logic hit_a, input logic hit_b);
    logic tog;
    logic high;
    logic low;
    tog = (hit_a && act_a == `TMR_ACT_TOGGLE) || (hit_b && act_b == `TMR_ACT_TOGGLE);
    high = (hit_a && act_a == `TMR_ACT_HIGH) || (hit_b && act_b == `TMR_ACT_HIGH);
    low = (hit_a && act_a == `TMR_ACT_LOW) || (hit_b && act_b == `TMR_ACT_LOW);
    if (tog) begin
      drive_out = ~cur;
    end else if (high) begin
      drive_out = 1'b1;
    end else if (low) begin
      drive_out = 1'b0;
    end else begin
      drive_out = cur;
    end
  endfunction

  logic [7:0] ctrl_reg;
  logic [2:0] flags_reg;
  logic [2:0] flags_next;
  logic [2:0] armed_reg;
  logic [3:0] os_reg;
  logic [7:0] const_a_reg;
  logic [7:0] const_b_reg;
  logic [7:0] cnt_reg;
  logic [7:0] cnt_next;
  logic [7:0] shared_serial_timer_ctrl_reg;
  logic [`TMR_PS_W-1:0] prescale_reg;
  logic [1:0] ext_sync_reg;
  logic [2:0] clr_sync_reg;
  logic out_reg;
  logic out_en_reg;
  tmr_irq_t irq_reg;
  logic [31:0] prdata_reg;
  logic pready_reg;
  logic pslverr_reg;

  // Bus decode
  wire setup_ph = psel & ~penable;
  wire access_ph = psel & penable & pready_reg;
  wire hit_ctrl = (paddr == `TMR_OFS_CTRL);
  wire hit_csr = (paddr == `TMR_OFS_CSR);
  wire hit_const_a = (paddr == `TMR_OFS_CONST_A);
  wire hit_const_b = (paddr == `TMR_OFS_CONST_B);
  wire hit_cnt = (paddr == `TMR_OFS_CNT);
  wire hit_shared_serial_timer_ctrl = (paddr == `TMR_OFS_SHARED_SERIAL_TIMER_CTRL);
  wire mapped = hit_ctrl | hit_csr | hit_const_a | hit_const_b | hit_cnt | hit_shared_serial_timer_ctrl;
  wire wr = access_ph & pwrite;
  wire wr_ctrl = wr & hit_ctrl;
  wire wr_csr = wr & hit_csr;
  wire wr_const_a = wr & hit_const_a;
  wire wr_const_b = wr & hit_const_b;
  wire wr_cnt = wr & hit_cnt;
  wire wr_shared_serial_timer_ctrl = wr & hit_shared_serial_timer_ctrl;
  wire rd_csr = setup_ph & ~pwrite & hit_csr;

  wire [7:0] csr_value = {flags_reg, 1'b1, os_reg};
  wire [7:0] rd_byte = hit_ctrl ? ctrl_reg :
                       hit_csr ? csr_value :
                       hit_const_a ? const_a_reg :
                       hit_const_b ? const_b_reg :
                       hit_cnt ? cnt_reg :
                       hit_shared_serial_timer_ctrl ? shared_serial_timer_ctrl_reg : 8'h00;

  // Count clock, compare and clear
  wire count_pulse;
  wire [1:0] cclr = ctrl_reg[`TMR_CTRL_CCLR_HI:`TMR_CTRL_CCLR_LO];
  wire [1:0] act_b = os_reg[`TMR_CSR_OS_B_HI:`TMR_CSR_OS_B_LO];
  wire [1:0] act_a = os_reg[`TMR_CSR_OS_A_HI:`TMR_CSR_OS_A_LO];
  wire match_a = count_pulse & (cnt_reg == const_a_reg) & ~wr_const_a;
  wire match_b = count_pulse & (cnt_reg == const_b_reg) & ~wr_const_b;
  wire clr_edge = clr_sync_reg[1] & ~clr_sync_reg[2];
  wire cnt_clear = ((cclr == `TMR_CCLR_MATCH_A) & match_a) | ((cclr == `TMR_CCLR_MATCH_B) & match_b) |
                   ((cclr == `TMR_CCLR_EXT) & clr_edge);
  wire wrap = count_pulse & (cnt_reg == `TMR_CNT_MAX) & ~cnt_clear & ~wr_cnt;
  wire [2:0] flag_set = {match_b, match_a, wrap};
  // A zero write clears only flags already seen as one by a read
  wire [2:0] flag_clr = {3{wr_csr}} & ~pwdata[`TMR_CSR_FLAG_HI:`TMR_CSR_FLAG_LO] & armed_reg;

  assign flags_next = (flags_reg & ~flag_clr) | flag_set;
  // Standby drops requests together with the flags they follow
  wire [2:0] irq_next = standby_req ? 3'h0 : (flags_next & ctrl_reg[`TMR_CTRL_IE_HI:`TMR_CTRL_IE_LO]);

  always_comb begin
    if (cnt_clear) begin
      cnt_next = `TMR_CNT_RST;
    end else if (wr_cnt) begin
      cnt_next = pwdata[7:0];
    end else if (count_pulse) begin
      cnt_next = cnt_reg + 8'h01;
    end else begin
      cnt_next = cnt_reg;
    end
  end

  tmr_clk_sel #(
    .CHANNEL(CHANNEL)
  ) u_clk_sel (
    .mclk(mclk),
    .rst_n(rst_n),
    .clk_sel(ctrl_reg[`TMR_CTRL_CKS_HI:`TMR_CTRL_CKS_LO]),
    .int_range_sel(shared_serial_timer_ctrl_reg[`TMR_SHARED_SERIAL_TIMER_CTRL_RANGE_HI:`TMR_SHARED_SERIAL_TIMER_CTRL_RANGE_LO]),
    .prescale(prescale_reg),
    .ext_level(ext_sync_reg[1]),
    .count_pulse(count_pulse)
  );

  // Pin synchronisers and prescaler
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ext_sync_reg <= 2'h0;
      clr_sync_reg <= 3'h0;
      prescale_reg <= '0;
    end else begin
      ext_sync_reg <= {ext_sync_reg[0], ext_count_clock_pin};
      clr_sync_reg <= {clr_sync_reg[1:0], counter_clear_pin};
      prescale_reg <= prescale_reg + 11'h001;
    end
  end

  // Bus answer: one wait-free access phase after every setup
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= 32'h0000_0000;
    end else begin
      pready_reg <= setup_ph;
      pslverr_reg <= setup_ph & ~mapped;
      if (setup_ph) begin
        prdata_reg <= {24'h00_0000, rd_byte};
      end
    end
  end

  // Timer registers; standby reinitialises all but the shared register
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_reg <= `TMR_CTRL_RST;
      flags_reg <= 3'(`TMR_CSR_RST >> `TMR_CSR_FLAG_LO);
      os_reg <= 4'h0;
      armed_reg <= 3'h0;
      const_a_reg <= `TMR_CONST_RST;
      const_b_reg <= `TMR_CONST_RST;
      cnt_reg <= `TMR_CNT_RST;
    end else if (standby_req) begin
      ctrl_reg <= `TMR_CTRL_RST;
      flags_reg <= 3'h0;
      os_reg <= 4'h0;
      armed_reg <= 3'h0;
      const_a_reg <= `TMR_CONST_RST;
      const_b_reg <= `TMR_CONST_RST;
      cnt_reg <= `TMR_CNT_RST;
    end else begin
      if (wr_ctrl) begin
        ctrl_reg <= pwdata[7:0];
      end
      if (wr_csr) begin
        os_reg <= pwdata[`TMR_CSR_OS_B_HI:`TMR_CSR_OS_A_LO];
      end
      if (wr_const_a) begin
        const_a_reg <= pwdata[7:0];
      end
      if (wr_const_b) begin
        const_b_reg <= pwdata[7:0];
      end
      flags_reg <= flags_next;
      armed_reg <= rd_csr ? flags_reg : (armed_reg & flags_next);
      cnt_reg <= cnt_next;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      shared_serial_timer_ctrl_reg <= `TMR_SHARED_SERIAL_TIMER_CTRL_RST;
    end else if (wr_shared_serial_timer_ctrl) begin
      shared_serial_timer_ctrl_reg <= pwdata[7:0];
    end
  end

  // Timer output and interrupt requests
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      out_reg <= 1'b0;
      out_en_reg <= 1'b0;
      irq_reg <= '0;
    end else begin
      out_reg <= drive_out(out_reg, act_a, act_b, match_a, match_b);
      out_en_reg <= |os_reg;
      irq_reg <= irq_next;
    end
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign timer_out_pin = out_reg;
  assign timer_out_en = out_en_reg;
  assign timer_irq = irq_reg;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  logic seen_match_reg;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      seen_match_reg <= 1'b0;
    end else if (match_a | match_b) begin
      seen_match_reg <= 1'b1;
    end
  end

  sequence stopped_two;
    (ctrl_reg[2:0] == 3'h0 || ctrl_reg[2:0] == 3'h4) [*2];
  endsequence

  sequence csr_write_ones;
    wr_csr && pwdata[7:5] == 3'h7;
  endsequence

  chk_flag_no_sw_set: assert property (csr_write_ones ##0 flags_reg == 3'h0 && flag_set == 3'h0 |=> flags_reg == 3'h0)
    else $error("software write set a status flag");
  chk_clear_needs_read: assert property (wr_csr && !standby_req && armed_reg == 3'h0
                                         |=> (flags_reg & $past(flags_reg)) == $past(flags_reg))
    else $error("flag cleared without prior read");
  chk_match_b_flag: assert property (match_b && !standby_req |=> flags_reg[2] && csr_value[`TMR_CSR_FLAG_B])
    else $error("match B did not set flag");
  chk_match_a_flag: assert property (match_a && !standby_req |=> csr_value[`TMR_CSR_FLAG_A])
    else $error("match A did not set flag");
  chk_wrap_flag: assert property (wrap && !standby_req |=> csr_value[`TMR_CSR_FLAG_WRAP] && cnt_reg == 8'h00)
    else $error("wrap did not set flag");
  chk_fixed_one: assert property (psel && penable && pready && !pwrite && hit_csr |-> prdata[`TMR_CSR_FIXED])
    else $error("reserved status bit not one");
  chk_standby_init: assert property (standby_req |=> csr_value == 8'h10 && cnt_reg == 8'h00)
    else $error("standby did not reinitialise status");
  chk_toggle_wins: assert property (match_a && match_b && (act_a == 2'h3 || act_b == 2'h3)
                                    |=> timer_out_pin != $past(timer_out_pin))
    else $error("toggle lost to drive high");
  chk_output_off: assert property (os_reg == 4'h0 |=> !timer_out_en)
    else $error("output enabled with select bits zero");
  chk_out_low_reset: assert property (!seen_match_reg |-> !timer_out_pin)
    else $error("output moved before any match");
  chk_shared_serial_timer_ctrl_standby: assert property (standby_req && !wr_shared_serial_timer_ctrl |=> $stable(shared_serial_timer_ctrl_reg))
    else $error("shared register changed in standby");
  chk_irq_follow: assert property (flags_reg[1] && ctrl_reg[6] && !wr_csr && !standby_req |=> timer_irq.match_a)
    else $error("match A request missing");
  chk_match_on_pulse: assert property ($rose(flags_reg[1]) |-> $past(count_pulse) && $past(cnt_reg == const_a_reg))
    else $error("flag A set away from a counting match");
  chk_stop_holds: assert property (stopped_two ##0 !wr_cnt && !cnt_clear && !standby_req |=> $stable(cnt_reg))
    else $error("stopped counter moved");
endmodule

// ===== sim/tmr_ext_src.sv
// Partner model: external count clock source and pulled-down output load
`timescale 1ns/1ns
module tmr_ext_src (
  input wire logic mclk,
  input wire logic go,
  input wire logic [7:0] pulses,
  input wire logic out_pin,
  input wire logic out_en,
  output logic ext_clk,
  output logic busy,
  output wire logic load_level
);
  // Pulled-down load sees low while output disabled
  assign load_level = out_en ? out_pin : 1'b0;
  initial begin
    ext_clk = 1'b0;
    busy = 1'b0;
    forever begin
      @(posedge mclk);
      if (go) begin
        busy <= 1'b1;
        // Four-cycle phases, wider than the minimum pulse width
        repeat (pulses) begin
          repeat (4) @(posedge mclk);
          ext_clk <= 1'b1;
          repeat (4) @(posedge mclk);
          ext_clk <= 1'b0;
        end
        @(posedge mclk);
        busy <= 1'b0;
      end
    end
  end
endmodule

// ===== sim/tmr_top_bench.sv
// Self-checking bench for both range tables of the timer channel
`timescale 1ns/1ns
`include "tmr_defs.svh"
module tmr_top_bench;
  import tmr_pkg::*;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic [1:0] psel_v = 2'b00;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic standby_req = 1'b0;
  logic go = 1'b0;
  logic [7:0] pulses = 8'h00;
  logic ch = 1'b0;
  logic last_err;
  logic [31:0] prdata0, prdata1;
  logic pready0, pready1, pslverr0, pslverr1, out_pin, out_en, ext_clk, busy;
  wire load;
  tmr_irq_t irq;
  int fails = 0;
  int checked = 0;
  int cycles = 0;
  wire [31:0] rdata = ch ? prdata1 : prdata0;
  wire rdy = ch ? pready1 : pready0;
  wire err = ch ? pslverr1 : pslverr0;

  tmr_top #(.CHANNEL(1'b0)) tmr_top_inst (.mclk(mclk), .rst_n(rst_n), .psel(psel_v[0]), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata0), .pready(pready0), .pslverr(pslverr0),
    .standby_req(standby_req), .ext_count_clock_pin(ext_clk), .counter_clear_pin(1'b0),
    .timer_out_pin(out_pin), .timer_out_en(out_en), .timer_irq(irq));
  tmr_top #(.CHANNEL(1'b1)) tmr_top_ch1_inst (.mclk(mclk), .rst_n(rst_n), .psel(psel_v[1]), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata1), .pready(pready1), .pslverr(pslverr1),
    .standby_req(standby_req), .ext_count_clock_pin(ext_clk), .counter_clear_pin(1'b0),
    .timer_out_pin(), .timer_out_en(), .timer_irq());
  tmr_ext_src tmr_ext_src_inst (.mclk(mclk), .go(go), .pulses(pulses), .out_pin(out_pin), .out_en(out_en),
    .ext_clk(ext_clk), .busy(busy), .load_level(load));

  always #20 mclk = ~mclk;

  task automatic stop_test();
    $display("Comparisons %0d, mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  always @(posedge mclk) begin
    cycles++;
    if (cycles == 60000) begin
      fails++;
      stop_test();
    end
  end

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk1(input logic got, input logic exp);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One APB transfer, request held until pready is seen
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
    psel_v[ch] <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge mclk);
    penable <= 1'b1;
    @(posedge mclk);
    while (rdy !== 1'b1) begin
      @(posedge mclk);
    end
    q = rdata[7:0];
    last_err = err;
    psel_v <= 2'b00;
    penable <= 1'b0;
    // Idle edge between transfers
    @(posedge mclk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] q;
    apb(1'b1, a, d, q);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] q;
    apb(1'b0, a, 8'h00, q);
    chk8(q, e);
  endtask

  task automatic test_reset();
    ch = 1'b0;
    rd_chk(`TMR_OFS_CSR, `TMR_CSR_RST);
    rd_chk(`TMR_OFS_SHARED_SERIAL_TIMER_CTRL, `TMR_SHARED_SERIAL_TIMER_CTRL_RST);
    rd_chk(`TMR_OFS_CONST_B, `TMR_CONST_RST);
    chk1(out_pin, 1'b0);
    chk1(out_en, 1'b0);
    wr(`TMR_OFS_CSR, 8'hE0);
    rd_chk(`TMR_OFS_CSR, 8'h10);
    rd_chk(8'h40, 8'h00);
    chk1(last_err, 1'b1);
  endtask

  // Increments over a window of four source periods
  task automatic rate(input logic c, input logic [7:0] shared_serial_timer_ctrl, input logic [2:0] cks, input int div);
    logic [7:0] c0;
    logic [7:0] c1;
    ch = c;
    wr(`TMR_OFS_SHARED_SERIAL_TIMER_CTRL, shared_serial_timer_ctrl);
    wr(`TMR_OFS_CTRL, {5'h00, cks});
    repeat (4) @(posedge mclk);
    apb(1'b0, `TMR_OFS_CNT, 8'h00, c0);
    repeat (div == 0 ? 62 : 4 * div - 3) @(posedge mclk);
    apb(1'b0, `TMR_OFS_CNT, 8'h00, c1);
    chk8(c1 - c0, div == 0 ? 8'h00 : 8'h04);
    wr(`TMR_OFS_CTRL, 8'h00);
  endtask

  task automatic test_rates();
    int d0[6] = '{8, 2, 64, 32, 1024, 256};
    int d1[6] = '{8, 2, 64, 128, 1024, 2048};
    for (int i = 0; i < 6; i++) begin
      rate(1'b0, {7'h7E, i[0]}, 3'(i / 2 + 1), d0[i]);
      rate(1'b1, {6'h3F, i[0], 1'b0}, 3'(i / 2 + 1), d1[i]);
    end
    rate(1'b0, 8'h01, 3'h0, 0);
    rate(1'b0, 8'h01, 3'h4, 0);
  endtask

  task automatic test_ext();
    int n;
    ch = 1'b0;
    for (int i = 0; i < 4; i++) begin
      wr(`TMR_OFS_CTRL, {5'h00, 3'h4 + 3'(i)});
      wr(`TMR_OFS_CNT, 8'h00);
      pulses <= 8'h05;
      go <= 1'b1;
      @(posedge mclk);
      go <= 1'b0;
      @(posedge mclk);
      n = 0;
      while (busy === 1'b1 && n < 200) begin
        n++;
        @(posedge mclk);
      end
      repeat (6) @(posedge mclk);
      rd_chk(`TMR_OFS_CNT, i == 0 ? 8'h00 : (i == 3 ? 8'h0A : 8'h05));
    end
  endtask

  task automatic test_match();
    logic [3:0] oss[10] = '{4'h2, 4'h1, 4'h3, 4'h4, 4'h8, 4'hC, 4'h9, 4'h7, 4'hE, 4'h0};
    logic exps[10] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0};
    ch = 1'b0;
    wr(`TMR_OFS_SHARED_SERIAL_TIMER_CTRL, 8'h01);
    wr(`TMR_OFS_CONST_A, 8'h04);
    wr(`TMR_OFS_CONST_B, 8'h04);
    for (int i = 0; i < 10; i++) begin
      wr(`TMR_OFS_CNT, 8'h00);
      wr(`TMR_OFS_CSR, {4'h0, oss[i]});
      wr(`TMR_OFS_CTRL, 8'h41);
      repeat (20) @(posedge mclk);
      wr(`TMR_OFS_CTRL, 8'h00);
      rd_chk(`TMR_OFS_CSR, {4'hD, oss[i]});
      chk1(load, exps[i]);
      chk1(out_en, oss[i] != 4'h0);
      wr(`TMR_OFS_CSR, {4'h0, oss[i]});
    end
  endtask

  task automatic test_wrap();
    ch = 1'b0;
    wr(`TMR_OFS_CONST_A, 8'h80);
    wr(`TMR_OFS_CONST_B, 8'h80);
    wr(`TMR_OFS_CNT, 8'hFD);
    wr(`TMR_OFS_CTRL, 8'h21);
    repeat (16) @(posedge mclk);
    wr(`TMR_OFS_CTRL, 8'h20);
    chk8({5'h00, irq}, 8'h01);
    wr(`TMR_OFS_CSR, 8'h00);
    rd_chk(`TMR_OFS_CSR, 8'h30);
    wr(`TMR_OFS_CSR, 8'h00);
    rd_chk(`TMR_OFS_CSR, 8'h10);
    chk8({5'h00, irq}, 8'h00);
  endtask

  // Match clear on A then B: five external pulses give 1, 2, 3, clear, 1
  task automatic test_clear();
    ch = 1'b0;
    wr(`TMR_OFS_CONST_A, 8'h03);
    wr(`TMR_OFS_CONST_B, 8'h03);
    for (int j = 1; j < 3; j++) begin
      wr(`TMR_OFS_CSR, 8'h00);
      wr(`TMR_OFS_CNT, 8'h00);
      wr(`TMR_OFS_CTRL, {3'h0, 2'(j), 3'h5});
      pulses <= 8'h05;
      go <= 1'b1;
      @(posedge mclk);
      go <= 1'b0;
      @(posedge mclk);
      while (busy === 1'b1) begin
        @(posedge mclk);
      end
      repeat (6) @(posedge mclk);
      rd_chk(`TMR_OFS_CNT, 8'h01);
      rd_chk(`TMR_OFS_CSR, 8'hD0);
    end
  endtask

  task automatic test_standby();
    ch = 1'b0;
    wr(`TMR_OFS_SHARED_SERIAL_TIMER_CTRL, 8'h03);
    wr(`TMR_OFS_CSR, 8'h0F);
    standby_req <= 1'b1;
    repeat (2) @(posedge mclk);
    standby_req <= 1'b0;
    rd_chk(`TMR_OFS_CSR, 8'h10);
    rd_chk(`TMR_OFS_SHARED_SERIAL_TIMER_CTRL, 8'h03);
    rd_chk(`TMR_OFS_CTRL, `TMR_CTRL_RST);
  endtask

  initial begin
    repeat (2) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    test_reset();
    test_rates();
    test_ext();
    test_match();
    test_wrap();
    test_clear();
    test_standby();
    stop_test();
  end
endmodule
